// ---- tto_pkg.sv ----
// Constants and types for the timer trigger-output and compare-update block.
// Assumes a single timer clock domain shared by every user of this package.
// Operation
// - Select code 010 drives the trigger output from the counter update event.
// - Select code 011 pulses the trigger output on every channel 1 capture or compare hit.
// - Select code 100 passes the channel 1 compare reference to the trigger output.
// - Select code 101 passes the channel 2 compare reference to the trigger output.
// - Select code 110 passes the channel 3 compare reference to the trigger output.
// - Select code 111 passes the channel 4 compare reference to the trigger output.
// - With the DMA source bit at 1 every channel value DMA request follows the update event.
// - With the DMA source bit at 0 each DMA request follows its own channel event.
// - With preload on and update source at 1, a commutation request or trigger rise commits.
// - With preload on and update source at 0, only a commutation request commits.
// - With preload on, channel 1-3 enable, complementary enable and mode writes wait for a commit; channel 4 writes apply at once.
// - With preload off, those writes take effect at once.
package tto_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int unsigned NUM_CH   = 4;
   localparam int unsigned NUM_COMP = 3;
   localparam int unsigned MODE_W   = 3;
   localparam int unsigned SEL_W    = 3;
   localparam int unsigned ACT_MODE_W  = NUM_CH * MODE_W;
   localparam int unsigned PEND_MODE_W = NUM_COMP * MODE_W;
   localparam int unsigned CH4_IDX  = 3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [NUM_CH-1:0]      EN_RST        = 4'h0;
   localparam logic [NUM_COMP-1:0]    CEN_RST       = 3'h0;
   localparam logic [ACT_MODE_W-1:0]  MODE_RST      = 12'h000;
   localparam logic [PEND_MODE_W-1:0] PEND_MODE_RST = 9'h000;
   localparam logic [NUM_CH-1:0]      DMA_ALL       = 4'hF;
   localparam logic [NUM_CH-1:0]      DMA_NONE      = 4'h0;

   // ****************************************************************
   // Trigger output source selection
   // ****************************************************************
   typedef enum logic [SEL_W-1:0] {
      SEL_RESET  = 3'h0,
      SEL_ENABLE = 3'h1,
      SEL_UPDATE = 3'h2,
      SEL_PULSE  = 3'h3,
      SEL_REF1   = 3'h4,
      SEL_REF2   = 3'h5,
      SEL_REF3   = 3'h6,
      SEL_REF4   = 3'h7
   } tto_trig_sel_e;

endpackage : tto_pkg

// ---- tto_preload_if.sv ----
// Interface between the trigger/update control and the channel control store.
// Assumes both ends run on the same timer clock.
`timescale 1ns/1ps
interface tto_preload_if;
   logic                                 wr;
   logic [tto_pkg::NUM_CH-1:0]           wr_en;
   logic [tto_pkg::NUM_COMP-1:0]         wr_cen;
   logic [tto_pkg::ACT_MODE_W-1:0]       wr_mode;
   logic                                 preload;
   logic                                 commit;
   logic [tto_pkg::NUM_CH-1:0]           act_en;
   logic [tto_pkg::NUM_COMP-1:0]         act_cen;
   logic [tto_pkg::ACT_MODE_W-1:0]       act_mode;
   logic [tto_pkg::NUM_COMP-1:0]         pend_en;
   logic [tto_pkg::NUM_COMP-1:0]         pend_cen;
   logic [tto_pkg::PEND_MODE_W-1:0]      pend_mode;

   modport ctl (output wr, wr_en, wr_cen, wr_mode, preload, commit,
                input  act_en, act_cen, act_mode, pend_en, pend_cen, pend_mode);
   modport store (input  wr, wr_en, wr_cen, wr_mode, preload, commit,
                  output act_en, act_cen, act_mode, pend_en, pend_cen, pend_mode);
endinterface : tto_preload_if

// ---- tto_preload.sv ----
// Channel control store: pending and active enable, complementary enable and mode.
// Assumes commit is a one-cycle strobe; only channels with complementary outputs preload.
`timescale 1ns/1ps
module tto_preload (
   input  wire logic   ref_clk_i,
   input  wire logic   arst_n_i,
   tto_preload_if.store pl
);

   // ****************************************************************
   // Complementary channels: pending copy plus active copy
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < tto_pkg::NUM_COMP; i++) begin : g_comp
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               pl.pend_en[i]                   <= 1'b0;
               pl.pend_cen[i]                  <= 1'b0;
               pl.pend_mode[i*tto_pkg::MODE_W +: tto_pkg::MODE_W] <= '0;
            end else if (pl.wr) begin
               pl.pend_en[i]                   <= pl.wr_en[i];
               pl.pend_cen[i]                  <= pl.wr_cen[i];
               pl.pend_mode[i*tto_pkg::MODE_W +: tto_pkg::MODE_W] <=
                  pl.wr_mode[i*tto_pkg::MODE_W +: tto_pkg::MODE_W];
            end
         end

         // A write in the commit cycle is committed too, so it is never stranded
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               pl.act_en[i]                    <= 1'b0;
               pl.act_cen[i]                   <= 1'b0;
               pl.act_mode[i*tto_pkg::MODE_W +: tto_pkg::MODE_W] <= '0;
            end else if (pl.wr && (!pl.preload || pl.commit)) begin
               pl.act_en[i]                    <= pl.wr_en[i];
               pl.act_cen[i]                   <= pl.wr_cen[i];
               pl.act_mode[i*tto_pkg::MODE_W +: tto_pkg::MODE_W] <=
                  pl.wr_mode[i*tto_pkg::MODE_W +: tto_pkg::MODE_W];
            end else if (pl.preload && pl.commit) begin
               pl.act_en[i]                    <= pl.pend_en[i];
               pl.act_cen[i]                   <= pl.pend_cen[i];
               pl.act_mode[i*tto_pkg::MODE_W +: tto_pkg::MODE_W] <=
                  pl.pend_mode[i*tto_pkg::MODE_W +: tto_pkg::MODE_W];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Channel 4 has no complementary output and is never preloaded
   // ****************************************************************
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pl.act_en[tto_pkg::CH4_IDX]  <= 1'b0;
         pl.act_mode[tto_pkg::CH4_IDX*tto_pkg::MODE_W +: tto_pkg::MODE_W] <= '0;
      end else if (pl.wr) begin
         pl.act_en[tto_pkg::CH4_IDX]  <= pl.wr_en[tto_pkg::CH4_IDX];
         pl.act_mode[tto_pkg::CH4_IDX*tto_pkg::MODE_W +: tto_pkg::MODE_W] <=
            pl.wr_mode[tto_pkg::CH4_IDX*tto_pkg::MODE_W +: tto_pkg::MODE_W];
      end
   end

endmodule : tto_preload

// ---- tto_top.sv ----
// Trigger output selection, capture/compare DMA request routing and
// commit control for preloaded channel control bits.
// Assumes events, references and control bits come from logic on the
// timer clock; only the trigger input arrives from outside and is synchronised.
`timescale 1ns/1ps
module tto_top (
   input  wire logic                               ref_clk_i,
   input  wire logic                               arst_n_i,
   input  wire logic [tto_pkg::SEL_W-1:0]          trigger_select_i,
   input  wire logic                               update_event_i,
   input  wire logic [tto_pkg::NUM_CH-1:0]         channel_event_i,
   input  wire logic                               channel1_compare_reference_i,
   input  wire logic                               channel2_compare_reference_i,
   input  wire logic                               channel3_compare_reference_i,
   input  wire logic                               channel4_compare_reference_i,
   input  wire logic                               dma_source_select_i,
   input  wire logic                               update_source_select_i,
   input  wire logic                               preload_control_i,
   input  wire logic                               commutation_request_i,
   input  wire logic                               trigger_input_i,
   input  wire logic                               ctl_write_i,
   input  wire logic [tto_pkg::NUM_CH-1:0]         channel_output_enable_i,
   input  wire logic [tto_pkg::NUM_COMP-1:0]       channel_complementary_enable_i,
   input  wire logic [tto_pkg::ACT_MODE_W-1:0]     channel_output_mode_i,
   output logic                                    trigger_output_o,
   output logic [tto_pkg::NUM_CH-1:0]              dma_request_o,
   output logic [tto_pkg::NUM_CH-1:0]              channel_output_enable_o,
   output logic [tto_pkg::NUM_COMP-1:0]            channel_complementary_enable_o,
   output logic [tto_pkg::ACT_MODE_W-1:0]          channel_output_mode_o,
   output logic                                    commutation_event_o
);

   // ****************************************************************
   // Trigger input synchroniser and rising-edge detect
   // ****************************************************************
   logic trig_meta;
   logic trig_sync;
   logic trig_prev;
   logic trig_rise;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
      end else begin
         trig_meta <= trigger_input_i;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
      end
   end

   // Pin to commit costs three edges: two to synchronise, one to load the active bits
   assign trig_rise = trig_sync & ~trig_prev;

   // ****************************************************************
   // Trigger output selection
   // ****************************************************************
   tto_pkg::tto_trig_sel_e sel;
   logic                   next_trigger_output;

   assign sel = tto_pkg::tto_trig_sel_e'(trigger_select_i);

   // Registered so the output is glitch-free; costs one cycle of latency
   always_comb begin
      next_trigger_output = 1'b0;
      unique case (sel)
         tto_pkg::SEL_RESET:  next_trigger_output = 1'b0;
         tto_pkg::SEL_ENABLE: next_trigger_output = 1'b0;
         tto_pkg::SEL_UPDATE: next_trigger_output = update_event_i;
         tto_pkg::SEL_PULSE:  next_trigger_output = channel_event_i[0];
         tto_pkg::SEL_REF1:   next_trigger_output = channel1_compare_reference_i;
         tto_pkg::SEL_REF2:   next_trigger_output = channel2_compare_reference_i;
         tto_pkg::SEL_REF3:   next_trigger_output = channel3_compare_reference_i;
         tto_pkg::SEL_REF4:   next_trigger_output = channel4_compare_reference_i;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trigger_output_o <= 1'b0;
      end else begin
         trigger_output_o <= next_trigger_output;
      end
   end

   // ****************************************************************
   // Capture/compare DMA request routing
   // ****************************************************************
   // With the DMA source bit at 1 an update raises all four requests in one cycle; the DMA side orders them
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dma_request_o <= tto_pkg::DMA_NONE;
      end else if (dma_source_select_i) begin
         dma_request_o <= update_event_i ? tto_pkg::DMA_ALL : tto_pkg::DMA_NONE;
      end else begin
         dma_request_o <= channel_event_i;
      end
   end

   // ****************************************************************
   // Commit control for preloaded channel bits
   // ****************************************************************
   tto_preload_if pl ();
   logic          commit;

   // Trigger edges only count when the update source bit allows them
   assign commit = commutation_request_i | (update_source_select_i & trig_rise);

   assign pl.wr      = ctl_write_i;
   assign pl.wr_en   = channel_output_enable_i;
   assign pl.wr_cen  = channel_complementary_enable_i;
   assign pl.wr_mode = channel_output_mode_i;
   assign pl.preload = preload_control_i;
   assign pl.commit  = commit;

   tto_preload u_store (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .pl        (pl.store)
   );

   // Active bits come straight from the store's flops
   assign channel_output_enable_o        = pl.act_en;
   assign channel_complementary_enable_o = pl.act_cen;
   assign channel_output_mode_o          = pl.act_mode;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         commutation_event_o <= 1'b0;
      end else begin
         // With preload off a commit changes nothing, so it is not reported
         commutation_event_o <= commit & preload_control_i;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // Outputs are registered, so each check looks one edge after its cause

   property p_update_sel;
      (trigger_select_i == tto_pkg::SEL_UPDATE) |=> (trigger_output_o == $past(update_event_i));
   endproperty
   a_update_sel: assert property (p_update_sel)
      else $error("trigger output does not follow update event");

   property p_pulse_on_event;
      (trigger_select_i == tto_pkg::SEL_PULSE) && channel_event_i[0] |=> trigger_output_o;
   endproperty
   a_pulse_on_event: assert property (p_pulse_on_event)
      else $error("compare pulse missing on channel 1 event");

   property p_pulse_one_cycle;
      (trigger_select_i == tto_pkg::SEL_PULSE) && !channel_event_i[0] |=> !trigger_output_o;
   endproperty
   a_pulse_one_cycle: assert property (p_pulse_one_cycle)
      else $error("compare pulse longer than its event");

   property p_ref1_sel;
      (trigger_select_i == tto_pkg::SEL_REF1)
         |=> (trigger_output_o == $past(channel1_compare_reference_i));
   endproperty
   a_ref1_sel: assert property (p_ref1_sel)
      else $error("trigger output does not follow channel 1 reference");

   property p_ref2_sel;
      (trigger_select_i == tto_pkg::SEL_REF2)
         |=> (trigger_output_o == $past(channel2_compare_reference_i));
   endproperty
   a_ref2_sel: assert property (p_ref2_sel)
      else $error("trigger output does not follow channel 2 reference");

   property p_ref3_sel;
      (trigger_select_i == tto_pkg::SEL_REF3)
         |=> (trigger_output_o == $past(channel3_compare_reference_i));
   endproperty
   a_ref3_sel: assert property (p_ref3_sel)
      else $error("trigger output does not follow channel 3 reference");

   property p_ref4_sel;
      (trigger_select_i == tto_pkg::SEL_REF4)
         |=> (trigger_output_o == $past(channel4_compare_reference_i));
   endproperty
   a_ref4_sel: assert property (p_ref4_sel)
      else $error("trigger output does not follow channel 4 reference");

   // ****************************************************************
   // DMA request checks
   // ****************************************************************
   property p_dma_update;
      dma_source_select_i |=> (dma_request_o == ($past(update_event_i) ?
                               tto_pkg::DMA_ALL : tto_pkg::DMA_NONE));
   endproperty
   a_dma_update: assert property (p_dma_update)
      else $error("DMA requests do not follow update event");

   property p_dma_channel;
      !dma_source_select_i |=> (dma_request_o == $past(channel_event_i));
   endproperty
   a_dma_channel: assert property (p_dma_channel)
      else $error("DMA requests do not follow channel events");

   property p_dma_no_update;
      !dma_source_select_i && update_event_i && (channel_event_i == tto_pkg::DMA_NONE)
         |=> (dma_request_o == tto_pkg::DMA_NONE);
   endproperty
   a_dma_no_update: assert property (p_dma_no_update)
      else $error("update event raised a DMA request");

   // ****************************************************************
   // Channel control checks
   // ****************************************************************
   property p_trig_commit;
      preload_control_i && update_source_select_i && $rose(trig_sync) && !ctl_write_i
         |=> (channel_complementary_enable_o == $past(pl.pend_cen))
             && (channel_output_mode_o[tto_pkg::PEND_MODE_W-1:0] == $past(pl.pend_mode));
   endproperty
   a_trig_commit: assert property (p_trig_commit)
      else $error("trigger input edge did not commit pending bits");

   property p_trig_ignored;
      preload_control_i && !update_source_select_i && !commutation_request_i && !ctl_write_i
         |=> $stable(channel_complementary_enable_o) && $stable(channel_output_enable_o);
   endproperty
   a_trig_ignored: assert property (p_trig_ignored)
      else $error("channel bits changed without commutation request");

   property p_preload_hold;
      preload_control_i && ctl_write_i && !commit
         |=> $stable(channel_complementary_enable_o)
             && (pl.pend_cen == $past(channel_complementary_enable_i));
   endproperty
   a_preload_hold: assert property (p_preload_hold)
      else $error("preloaded write applied before commit");

   property p_direct_write;
      !preload_control_i && ctl_write_i
         |=> (channel_output_enable_o == $past(channel_output_enable_i))
             && (channel_output_mode_o == $past(channel_output_mode_i));
   endproperty
   a_direct_write: assert property (p_direct_write)
      else $error("direct write not applied at once");

   property p_sw_commit;
      preload_control_i && commutation_request_i && !ctl_write_i
         |=> (channel_complementary_enable_o == $past(pl.pend_cen))
             && (channel_output_enable_o[tto_pkg::NUM_COMP-1:0] == $past(pl.pend_en));
   endproperty
   a_sw_commit: assert property (p_sw_commit)
      else $error("commutation request did not commit");

   property p_write_on_commit;
      preload_control_i && ctl_write_i && commit
         |=> (channel_complementary_enable_o == $past(channel_complementary_enable_i));
   endproperty
   a_write_on_commit: assert property (p_write_on_commit)
      else $error("write in the commit cycle was lost");

   property p_ch4_direct;
      ctl_write_i |=> (channel_output_enable_o[tto_pkg::CH4_IDX]
                       == $past(channel_output_enable_i[tto_pkg::CH4_IDX]));
   endproperty
   a_ch4_direct: assert property (p_ch4_direct)
      else $error("channel 4 enable was preloaded");

   property p_hold_idle;
      !ctl_write_i && !commit
         |=> $stable(channel_output_enable_o) && $stable(channel_output_mode_o)
             && $stable(channel_complementary_enable_o);
   endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("channel bits changed without write or commit");

   property p_commit_flag;
      commit && preload_control_i |=> commutation_event_o;
   endproperty
   a_commit_flag: assert property (p_commit_flag)
      else $error("commit not reported");

   property p_trig_level;
      trig_sync && $stable(trig_sync) && !commutation_request_i
         |=> !commutation_event_o;
   endproperty
   a_trig_level: assert property (p_trig_level)
      else $error("held trigger input committed again");

   // ****************************************************************
   // Cover points
   // ****************************************************************
   c_pulse:      cover property ((trigger_select_i == tto_pkg::SEL_PULSE)
                                 && channel_event_i[0] ##1 trigger_output_o);
   c_trig_commit: cover property (preload_control_i && update_source_select_i
                                  && trig_rise ##1 commutation_event_o);
   c_sw_commit:  cover property (preload_control_i && commutation_request_i);
   c_dma_update: cover property (dma_source_select_i && update_event_i);
   c_wr_commit:  cover property (preload_control_i && ctl_write_i && commutation_request_i);

endmodule : tto_top

// ---- tto_slave_model.sv ----
// Slave timer model that consumes the trigger output as its prescaler clock.
// Assumes the trigger output is a registered level on the same timer clock.
`timescale 1ns/1ps
module tto_slave_model (
   input  wire logic       ref_clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       trigger_i,
   output logic [7:0]      tick_count_o
);
   logic prev;

   // ****************************************************************
   // Rising-edge counter
   // ****************************************************************
   // Counts edges, not levels, so merged pulses show up as one tick
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev         <= 1'b0;
         tick_count_o <= 8'h00;
      end else begin
         prev <= trigger_i;
         if (trigger_i && !prev) begin
            tick_count_o <= tick_count_o + 8'h01;
         end
      end
   end
endmodule : tto_slave_model

// ---- tb_timer_trigger_out_and_compare_update.sv ----
// Self-checking bench for the trigger-output, DMA routing and preload commit block.
// Assumes the package, interface, design and slave model are compiled first.
`timescale 1ns/1ps
module tb_timer_trigger_out_and_compare_update;
   logic                               ref_clk_i;
   logic                               arst_n_i;
   logic [tto_pkg::SEL_W-1:0]          sel;
   logic                               upd;
   logic [tto_pkg::NUM_CH-1:0]         ev;
   logic [3:0]                         refs;
   logic                               dss, uss, pre, commute, trg, wr;
   logic [tto_pkg::NUM_CH-1:0]         w_en;
   logic [tto_pkg::NUM_COMP-1:0]       w_cen;
   logic [tto_pkg::ACT_MODE_W-1:0]     w_mode;
   logic                               trig_o;
   logic [tto_pkg::NUM_CH-1:0]         dma_o, en_o;
   logic [tto_pkg::NUM_COMP-1:0]       cen_o;
   logic [tto_pkg::ACT_MODE_W-1:0]     mode_o;
   logic                               commute_evt;
   logic [7:0]                         ticks;
   int                                 n_mismatch = 0;
   int                                 checks = 0;

   tto_top uut (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .trigger_select_i(sel),
      .update_event_i(upd), .channel_event_i(ev),
      .channel1_compare_reference_i(refs[0]), .channel2_compare_reference_i(refs[1]),
      .channel3_compare_reference_i(refs[2]), .channel4_compare_reference_i(refs[3]),
      .dma_source_select_i(dss), .update_source_select_i(uss), .preload_control_i(pre),
      .commutation_request_i(commute), .trigger_input_i(trg), .ctl_write_i(wr),
      .channel_output_enable_i(w_en), .channel_complementary_enable_i(w_cen),
      .channel_output_mode_i(w_mode), .trigger_output_o(trig_o), .dma_request_o(dma_o),
      .channel_output_enable_o(en_o), .channel_complementary_enable_o(cen_o),
      .channel_output_mode_o(mode_o), .commutation_event_o(commute_evt));

   tto_slave_model slave (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .trigger_i(trig_o), .tick_count_o(ticks));

   // ****************************************************************
   // Shared helpers
   // ****************************************************************
   task automatic wrap_up();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask : chk

   // Drive at one edge; the design takes it at the next, answer read just after
   task automatic edge_settle();
      @(posedge ref_clk_i);
      #1;
   endtask : edge_settle

   task automatic wr_ctl(input logic [3:0] e, input logic [2:0] c, input logic [11:0] m);
      @(posedge ref_clk_i);
      wr <= 1'b1; w_en <= e; w_cen <= c; w_mode <= m;
      edge_settle();
      wr <= 1'b0;
   endtask : wr_ctl

   // Bounded wait for a commit to land on the complementary enables
   task automatic wait_cen(input logic [2:0] exp, output logic seen);
      int k;
      // The commit may already have landed, with its status pulse standing now
      seen = commute_evt;
      for (k = 0; k < 8 && cen_o !== exp; k++) begin
         edge_settle();
         seen = seen | commute_evt;
      end
      if (cen_o !== exp) begin
         $display("MISMATCH commit expected %h seen %h", exp, cen_o);
         n_mismatch++;
         wrap_up();
      end
   endtask : wait_cen

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Every code, each compare reference high alone and then low alone, update held high throughout
   task automatic t_trig_select();
      int i, p;
      logic exp_t;
      for (p = 0; p < 2; p++) begin
         for (i = 0; i < 8; i++) begin
            @(posedge ref_clk_i);
            sel  <= i[2:0];
            upd  <= 1'b1;
            refs <= (i >= 4) ? (4'h1 << (i - 4)) ^ {4{p[0]}} : {4{p[0]}};
            edge_settle();
            exp_t = (i == 2) || (i >= 4 && p == 0);
            chk("trigger_select", {11'h000, exp_t}, {11'h000, trig_o});
         end
      end
      upd <= 1'b0;
   endtask : t_trig_select

   // Two channel 1 events with one idle cycle between give two single-cycle pulses
   task automatic t_pulse();
      logic [7:0] t0;
      @(posedge ref_clk_i);
      sel <= tto_pkg::SEL_PULSE; refs <= 4'hF;
      edge_settle();
      t0 = ticks;
      ev <= 4'h1;
      edge_settle();
      ev <= 4'hE;
      chk("pulse_hi1", 12'h001, {11'h000, trig_o});
      edge_settle();
      ev <= 4'h1;
      chk("pulse_lo1", 12'h000, {11'h000, trig_o});
      edge_settle();
      ev <= 4'h0;
      chk("pulse_hi2", 12'h001, {11'h000, trig_o});
      edge_settle();
      chk("pulse_lo2", 12'h000, {11'h000, trig_o});
      edge_settle();
      chk("slave_ticks", 12'h002, {4'h0, ticks - t0});
   endtask : t_pulse

   task automatic t_dma();
      @(posedge ref_clk_i);
      dss <= 1'b1; upd <= 1'b1; ev <= 4'h5;
      edge_settle();
      upd <= 1'b0; ev <= 4'hA;
      chk("dma_on_update", {8'h00, tto_pkg::DMA_ALL}, {8'h00, dma_o});
      edge_settle();
      chk("dma_idle", {8'h00, tto_pkg::DMA_NONE}, {8'h00, dma_o});
      dss <= 1'b0; upd <= 1'b1; ev <= 4'h6;
      edge_settle();
      upd <= 1'b0; ev <= 4'h0;
      chk("dma_on_channel", 12'h006, {8'h00, dma_o});
   endtask : t_dma

   task automatic t_ctl_direct();
      @(posedge ref_clk_i);
      pre <= 1'b0;
      wr_ctl(4'h5, 3'h3, 12'h5A3);
      chk("en_direct", 12'h005, {8'h00, en_o});
      chk("cen_direct", 12'h003, {9'h000, cen_o});
      chk("mode_direct", 12'h5A3, mode_o);
   endtask : t_ctl_direct

   // Preloaded write held through an ignored trigger rise, then committed
   task automatic t_ctl_preload();
      logic seen;
      @(posedge ref_clk_i);
      pre <= 1'b1; uss <= 1'b0;
      wr_ctl(4'hA, 3'h4, 12'h9B6);
      chk("en_held", 12'h00D, {8'h00, en_o});
      chk("mode_held", 12'h9A3, mode_o);
      trg <= 1'b1;
      repeat (6) edge_settle();
      trg <= 1'b0;
      chk("cen_trig_ignored", 12'h003, {9'h000, cen_o});
      repeat (3) edge_settle();
      commute <= 1'b1;
      edge_settle();
      commute <= 1'b0;
      wait_cen(3'h4, seen);
      chk("en_commit", 12'h00A, {8'h00, en_o});
      chk("mode_commit", 12'h9B6, mode_o);
      chk("commit_event", 12'h001, {11'h000, seen});
      uss <= 1'b1;
      wr_ctl(4'h5, 3'h3, 12'h5A3);
      chk("cen_held2", 12'h004, {9'h000, cen_o});
      trg <= 1'b1;
      wait_cen(3'h3, seen);
      chk("mode_trig_commit", 12'h5A3, mode_o);
      trg <= 1'b0;
   endtask : t_ctl_preload

   // ****************************************************************
   // Clock, reset and main sequence
   // ****************************************************************
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      arst_n_i = 1'b0;
      sel = 3'h0; upd = 1'b0; ev = 4'h0; refs = 4'h0;
      dss = 1'b0; uss = 1'b0; pre = 1'b0; commute = 1'b0; trg = 1'b0;
      wr = 1'b0; w_en = 4'h0; w_cen = 3'h0; w_mode = 12'h000;
      repeat (10) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      t_trig_select();
      t_pulse();
      t_dma();
      t_ctl_direct();
      t_ctl_preload();
      wrap_up();
   end
endmodule : tb_timer_trigger_out_and_compare_update
